// ---- src/aic_defines.vh ----
// Register map, field positions, reset values and timing constants of the event conditioner
`ifndef AIC_DEFINES_VH
`define AIC_DEFINES_VH
// Register addresses (word offsets on the plain register port)
`define AIC_ADDR_W 8
`define AIC_OFS_STATUS 8'h7F
`define AIC_OFS_MASK 8'h80
`define AIC_OFS_POLARITY 8'h81
`define AIC_OFS_DEBOUNCE 8'h82
// Register data width
`define AIC_DATA_W 16
// Field positions shared by mask, polarity, debounce and status
`define AIC_BIT_BITCLK 9
`define AIC_BIT_SEQ 8
`define AIC_BIT_GP_PIN1 5
`define AIC_BIT_GP_IN8 4
`define AIC_BIT_GP_IN7 3
`define AIC_BIT_LOOP_LOCK 2
`define AIC_BIT_BIAS_SHORT 1
`define AIC_BIT_BIAS_DETECT 0
`define AIC_BIT_SUMMARY 10
// Implemented source bits within a register
`define AIC_SRC_BITS 16'h033F
// Reset values
`define AIC_RST_MASK 16'h033F
`define AIC_RST_POLARITY 16'h0000
`define AIC_RST_DEBOUNCE 16'h0000
`define AIC_RST_ZERO 16'h0000
// Debounce sampling period and stable-sample count
`define AIC_SAMPLE_NS 1000
`define AIC_CLK_NS 100
`define AIC_SAMPLE_CYC (`AIC_SAMPLE_NS / `AIC_CLK_NS)
`define AIC_STABLE_SAMPLES 4
`endif

// ---- src/aic_debounce.v ----
// Stable-sample debounce filter for one event condition
`include "aic_defines.vh"

module aic_debounce #(
	parameter CNT_W = 3,
	parameter [CNT_W-1:0] STABLE = `AIC_STABLE_SAMPLES
) (
	input wire core_clk,
	input wire nrst,
	input wire sample_en,
	input wire cond_in,
	output reg cond_out_q
);

	reg [CNT_W-1:0] stable_cnt_q; // Samples seen since the input last agreed with the output
	reg [CNT_W-1:0] stable_cnt_d;
	reg cond_out_d;

	// Counter restarts at each sample where the raw input agrees with the filtered output
	always @* begin
		stable_cnt_d = stable_cnt_q;
		cond_out_d = cond_out_q;
		if (sample_en) begin
			if (cond_in == cond_out_q) begin
				// Agreement, nothing pending
				stable_cnt_d = {CNT_W{1'b0}};
			end else if (stable_cnt_q == STABLE - 1'b1) begin
				cond_out_d = cond_in;
				stable_cnt_d = {CNT_W{1'b0}};
			end else begin
				stable_cnt_d = stable_cnt_q + 1'b1;
			end
		end
	end

	// State registers
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stable_cnt_q <= {CNT_W{1'b0}};
			cond_out_q <= 1'b0;
		end else begin
			stable_cnt_q <= stable_cnt_d;
			cond_out_q <= cond_out_d;
		end
	end

endmodule

// ---- src/aic_irq_cond.v ----
// Event conditioner: per-source mask, polarity, debounce, sticky flags and request
//
// The address-and-strobe port is this design's own decision.
`include "aic_defines.vh"

// How it works
// - Mask bit 1 removes source from request
// - All implemented mask bits reset to one
// - Polarity resets 0; 1 inverts the condition
// - Sequencer: busy flags at 0, idle at 1
// - Loop: lock at 0, unlocked at 1
// - Debounce bit routes condition through filter
// - All debounce bits reset to zero
// - Same bit positions in every register
// - Flags sticky, cleared by writing one
// - Summary bit is OR of flags
module aic_irq_cond #(
	parameter SAMPLE_CYC = `AIC_SAMPLE_CYC,
	parameter STABLE_SAMPLES = `AIC_STABLE_SAMPLES
) (
	input wire core_clk,
	input wire nrst,
	input wire [`AIC_ADDR_W-1:0] reg_addr,
	input wire [`AIC_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`AIC_DATA_W-1:0] reg_rdata_q,
	input wire bitclk_pin_in,
	input wire seq_busy,
	input wire gp_pin1_in,
	input wire gp_input8_in,
	input wire gp_input7_in,
	input wire loop_locked,
	input wire bias_short,
	input wire bias_detect,
	output reg irq_q
);

	localparam DW = `AIC_DATA_W;
	localparam SAMPLE_W = 16;

	reg [DW-1:0] irq_source_mask_q; // Set bit blocks the source
	reg [DW-1:0] irq_source_polarity_q; // Set bit means low is the event
	reg [DW-1:0] irq_source_debounce_q; // Set bit enables filtering
	reg [DW-1:0] flags_q; // Sticky per-source flags
	reg [DW-1:0] flags_d;
	reg [SAMPLE_W-1:0] sample_cnt_q; // Slow sample divider
	reg sample_en_q; // One-cycle sample enable
	wire [DW-1:0] raw_cond; // Conditions placed at their field positions
	wire [DW-1:0] pol_cond; // After polarity
	wire [DW-1:0] filt_cond; // After debounce filter
	wire [DW-1:0] event_cond; // Chosen per debounce bit
	wire [DW-1:0] wr_clear; // Write-one-to-clear pulses
	wire summary; // Any flag set
	wire irq_d;

	// True when a write strobe targets the given address
	function wr_hit;
		input wr;
		input [`AIC_ADDR_W-1:0] addr;
		input [`AIC_ADDR_W-1:0] target;
		begin
			wr_hit = wr && (addr == target);
		end
	endfunction

	assign raw_cond[`AIC_BIT_BITCLK] = bitclk_pin_in;
	assign raw_cond[`AIC_BIT_SEQ] = seq_busy;
	assign raw_cond[`AIC_BIT_GP_PIN1] = gp_pin1_in;
	assign raw_cond[`AIC_BIT_GP_IN8] = gp_input8_in;
	assign raw_cond[`AIC_BIT_GP_IN7] = gp_input7_in;
	assign raw_cond[`AIC_BIT_LOOP_LOCK] = loop_locked;
	assign raw_cond[`AIC_BIT_BIAS_SHORT] = bias_short;
	assign raw_cond[`AIC_BIT_BIAS_DETECT] = bias_detect;
	// Unused positions never raise events
	assign raw_cond[7:6] = 2'h0;
	assign raw_cond[DW-1:10] = 6'h00;

	assign pol_cond = (raw_cond ^ irq_source_polarity_q) & `AIC_SRC_BITS;

	// Divider for the slow debounce sample enable
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sample_cnt_q <= 16'h0000;
			sample_en_q <= 1'b0;
		end else if (sample_cnt_q == SAMPLE_CYC - 1) begin
			sample_cnt_q <= 16'h0000;
			sample_en_q <= 1'b1;
		end else begin
			sample_cnt_q <= sample_cnt_q + 16'h0001;
			sample_en_q <= 1'b0;
		end
	end

	// One filter per bit; unused positions are trimmed by synthesis
	genvar gi;
	generate
		for (gi = 0; gi < DW; gi = gi + 1) begin : g_db
			aic_debounce #(
				.CNT_W(3),
				.STABLE(STABLE_SAMPLES[2:0])
			) u_db (
				.core_clk(core_clk),
				.nrst(nrst),
				.sample_en(sample_en_q),
				.cond_in(pol_cond[gi]),
				.cond_out_q(filt_cond[gi])
			);
		end
	endgenerate

	assign event_cond = (irq_source_debounce_q & filt_cond) | (~irq_source_debounce_q & pol_cond);

	assign wr_clear = wr_hit(reg_wr, reg_addr, `AIC_OFS_STATUS) ? reg_wdata : `AIC_RST_ZERO;

	// Flags: set beats clear so an event in the clearing cycle survives
	always @* begin
		flags_d = ((flags_q & ~wr_clear) | event_cond) & `AIC_SRC_BITS;
	end

	assign summary = |flags_q;
	assign irq_d = |(flags_d & ~irq_source_mask_q);

	// Control registers and flags
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_source_mask_q <= `AIC_RST_MASK;
			irq_source_polarity_q <= `AIC_RST_POLARITY;
			irq_source_debounce_q <= `AIC_RST_DEBOUNCE;
			flags_q <= `AIC_RST_ZERO;
			irq_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			irq_q <= irq_d;
			if (wr_hit(reg_wr, reg_addr, `AIC_OFS_MASK)) begin
				irq_source_mask_q <= reg_wdata & `AIC_SRC_BITS;
			end
			if (wr_hit(reg_wr, reg_addr, `AIC_OFS_POLARITY)) begin
				irq_source_polarity_q <= reg_wdata & `AIC_SRC_BITS;
			end
			if (wr_hit(reg_wr, reg_addr, `AIC_OFS_DEBOUNCE)) begin
				irq_source_debounce_q <= reg_wdata & `AIC_SRC_BITS;
			end
		end
	end

	// Read data valid the cycle after the strobe; unmapped reads give zero
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q <= `AIC_RST_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				`AIC_OFS_STATUS: reg_rdata_q <= flags_q | ({{(DW-1){1'b0}}, summary} << `AIC_BIT_SUMMARY);
				`AIC_OFS_MASK: reg_rdata_q <= irq_source_mask_q;
				`AIC_OFS_POLARITY: reg_rdata_q <= irq_source_polarity_q;
				`AIC_OFS_DEBOUNCE: reg_rdata_q <= irq_source_debounce_q;
				default: reg_rdata_q <= `AIC_RST_ZERO;
			endcase
		end else begin
			reg_rdata_q <= `AIC_RST_ZERO;
		end
	end

endmodule

// ---- testbench/aic_irq_cond_asserts.sv ----
// Checker of the conditioner register port and request
module aic_chk (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata_q,
	input wire logic irq_q
);
	timeunit 1ns;
	timeprecision 1ns;
	// Registers written since reset
	logic [3:0] wr_q;
	// Reset values only hold until the first write
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			wr_q <= 4'h0;
		else if (reg_wr && reg_addr[7:2] == 6'h20)
			wr_q[reg_addr[1:0]] <= 1'b1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
		else $error("read data not idle");
	AST_MASK_RST: assert property (reg_rd && reg_addr == 8'h80 && !wr_q[0] |=> reg_rdata_q == 16'h033F)
		else $error("mask reset value");
	AST_POL_RST: assert property (reg_rd && reg_addr == 8'h81 && !wr_q[1] |=> reg_rdata_q == 16'h0000)
		else $error("polarity reset value");
	AST_DB_RST: assert property (reg_rd && reg_addr == 8'h82 && !wr_q[2] |=> reg_rdata_q == 16'h0000)
		else $error("debounce reset value");
	AST_NO_IRQ: assert property (!wr_q[0] |-> !irq_q)
		else $error("request while all masked");
	AST_SUM: assert property (reg_rd && reg_addr == 8'h7F |=> reg_rdata_q[10] == |reg_rdata_q[9:0])
		else $error("summary bit");
	AST_UNIMP: assert property (reg_rd |=> (reg_rdata_q & 16'hF8C0) == 16'h0000)
		else $error("unused bits set");
	AST_IRQ_MASK: assert property (reg_wr && reg_addr == 8'h80 && (reg_wdata & 16'h033F) == 16'h033F |=> ##1 !irq_q)
		else $error("request after full mask");
	cover property (reg_rd && reg_addr == 8'h7F ##1 reg_rdata_q[10]);
	cover property ($rose(irq_q));
	cover property (reg_wr && reg_addr == 8'h82 && reg_wdata != 16'h0000);
endmodule
bind aic_irq_cond aic_chk u_chk (.*);

// ---- testbench/aic_host.sv ----
// Host model: register bus master driven by the bench tasks; it has no request input
module aic_host (
	input wire logic core_clk,
	input wire logic seq_busy,
	input wire logic [15:0] reg_rdata_q,
	output logic [7:0] reg_addr = 8'h00,
	output logic [15:0] reg_wdata = 16'h0000,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// One write cycle, entered just after an edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		// Strobe rests one cycle so a following call never reassigns it in this step
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// One read cycle; data taken at the edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata_q;
		if (seq_busy)
			d[8] = 1'b0;
	endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench of the event conditioner
`include "aic_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] src = 8'h00; // Conditions, bit 7 down to 0 in port order
	wire [7:0] reg_addr;
	wire [15:0] reg_wdata, reg_rdata_q;
	wire reg_wr, reg_rd, irq_q;
	int failures = 0;
	int check_count = 0;
	int seed = 32'h2EA5;
	aic_host u_host (.core_clk(core_clk), .seq_busy(src[6]), .reg_rdata_q(reg_rdata_q),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	// Short debounce sampling keeps the run brief
	aic_irq_cond #(.SAMPLE_CYC(2), .STABLE_SAMPLES(4)) DUT (.core_clk(core_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .bitclk_pin_in(src[7]), .seq_busy(src[6]),
		.gp_pin1_in(src[5]), .gp_input8_in(src[4]), .gp_input7_in(src[3]),
		.loop_locked(src[2]), .bias_short(src[1]), .bias_detect(src[0]), .irq_q(irq_q));
	initial forever #50 core_clk = ~core_clk;
	// Packed conditions to register bit positions
	function automatic logic [15:0] spread(input logic [7:0] v);
		return {6'h00, v[7:6], 2'b00, v[5:0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request level compare
	task automatic chk_irq(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t irq got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		u_host.rd(a, d);
		chk(d, e);
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		logic [7:0] p, m;
		logic [15:0] f, g;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		u_host.wr(8'h90, 16'hFFFF);
		rc(`AIC_OFS_MASK, 16'h033F);
		rc(`AIC_OFS_POLARITY, 16'h0000);
		rc(`AIC_OFS_DEBOUNCE, 16'h0000);
		rc(`AIC_OFS_STATUS, 16'h0000);
		rc(8'h90, 16'h0000);
		$display("test reset done");
		// Random conditions, polarity and mask
		repeat (40) begin
			p = 8'($random(seed));
			m = 8'($random(seed));
			src <= 8'($random(seed));
			u_host.wr(`AIC_OFS_POLARITY, spread(p));
			u_host.wr(`AIC_OFS_MASK, spread(m));
			u_host.wr(`AIC_OFS_STATUS, 16'h033F);
			g = spread(src ^ p);
			g[10] = |g;
			f = g;
			f[8] = f[8] & !src[6];
			rc(`AIC_OFS_STATUS, f);
			chk_irq(irq_q, |(g[9:0] & ~spread(m)));
			src <= p;
			f = g;
			f[8] = f[8] & !p[6];
			rc(`AIC_OFS_STATUS, f);
			u_host.wr(`AIC_OFS_STATUS, 16'h033F);
			rc(`AIC_OFS_STATUS, 16'h0000);
			chk_irq(irq_q, 1'b0);
		end
		$display("test random done");
		// Filtered path needs several stable samples
		src <= 8'h00;
		u_host.wr(`AIC_OFS_POLARITY, 16'h0000);
		u_host.wr(`AIC_OFS_DEBOUNCE, 16'h033F);
		repeat (20) @(posedge core_clk);
		u_host.wr(`AIC_OFS_STATUS, 16'h033F);
		src <= 8'h01;
		// Direct path would have set the flag by now; the filter must still hold it off
		repeat (4) @(posedge core_clk);
		rc(`AIC_OFS_STATUS, 16'h0000);
		repeat (20) @(posedge core_clk);
		rc(`AIC_OFS_STATUS, 16'h0401);
		// Unmask the set source, then mask all; request follows one edge after the write
		u_host.wr(`AIC_OFS_MASK, 16'h033E);
		@(posedge core_clk);
		chk_irq(irq_q, 1'b1);
		u_host.wr(`AIC_OFS_MASK, 16'h033F);
		@(posedge core_clk);
		chk_irq(irq_q, 1'b0);
		$display("test debounce done");
		final_report();
	end
	// Hang guard
	initial begin
		#(20000 * 100);
		failures++;
		final_report();
	end
endmodule
